// ===== rtl/pmsr_defines.vh
// register offsets, field positions and reset values of the regulator register bank
`ifndef PMSR_DEFINES_VH
`define PMSR_DEFINES_VH

`define PMSR_ADDR_BAT_MON 8'h00
`define PMSR_ADDR_THERM 8'h01
`define PMSR_ADDR_B1_CTRL 8'h12
`define PMSR_ADDR_B2_PRI 8'h20
`define PMSR_ADDR_B2_SEC 8'h21
`define PMSR_ADDR_B2_CTRL 8'h22
`define PMSR_ADDR_B3_PRI 8'h30

`define PMSR_BIT_UNMASK 7
`define PMSR_BIT_FLAG 6
`define PMSR_BIT_BAT_LIVE 5
`define PMSR_BIT_BAT_SPARE 4
`define PMSR_BIT_ENABLE 7
`define PMSR_BIT_PHASE 2
`define PMSR_BIT_FAULT_UNMASK 1
`define PMSR_BIT_PGOOD 0

`define PMSR_RST_BAT_MON 8'h00
`define PMSR_RST_THERM 8'h00
`define PMSR_RST_CTRL 8'h00
`define PMSR_RST_VCODE 6'h00

`endif

// ===== rtl/pmsr_sync.v
// two-flop synchroniser for a bus of asynchronous status inputs
`timescale 1ns/1ps
module pmsr_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  input wire clk_en,
  // data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  always @(posedge clock) begin
    if (!nrst) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

// ===== rtl/pmsr_regs.v
// control and status register bank for battery, thermal and buck regulators
// Function
// - battery register bit 7 unmasks battery interrupt
// - battery bit 6 shows battery interrupt generated
// - battery bit 5 shows live low-battery comparator
// - battery bits 3:0 hold threshold code
// - thermal register bit 7 unmasks thermal interrupt
// - thermal bit 6 shows thermal interrupt generated
// - control bit 7 enables the regulator
// - control bit 2 selects 180 degree phase
// - control bit 1 permits regulator fault interrupts
// - control bit 0 reports power good
// - primary code applies while select pin low
// - buck two secondary code applies while select pin high; buck three always uses its primary code
`timescale 1ns/1ps
`include "pmsr_defines.vh"
module pmsr_regs (
  // clock and reset
  input wire clock,
  input wire nrst,
  input wire clk_en,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // analog status pins
  input wire battery_low_cmp,
  input wire thermal_event,
  input wire [1:0] buck_pgood,
  input wire [1:0] buck_fault,
  input wire voltage_select_pin,
  // regulator controls
  output reg [3:0] battery_threshold_code,
  output reg [1:0] buck_enable,
  output reg [1:0] buck_phase,
  output reg [5:0] buck_two_vcode,
  output reg [5:0] buck_three_vcode,
  output reg irq_request
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  wire [6:0] sync_bus;

  pmsr_sync #(
    .WIDTH(7)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .async_in({voltage_select_pin, buck_fault, buck_pgood, thermal_event, battery_low_cmp}),
    .sync_out(sync_bus)
  );

  wire battery_low_live = sync_bus[0];
  wire thermal_live = sync_bus[1];
  wire [1:0] pgood_live = sync_bus[3:2];
  wire [1:0] fault_live = sync_bus[5:4];
  wire voltage_select_pin_live = sync_bus[6];

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg battery_irq_unmask;
  reg battery_irq_flag;
  reg battery_spare;
  reg thermal_irq_unmask;
  reg thermal_irq_flag;
  reg [5:0] thermal_spare;
  reg [1:0] fault_irq_unmask;
  reg [5:0] primary_voltage_code;
  reg [5:0] secondary_voltage_code;
  reg [5:0] b3_primary_voltage_code;

  wire wr_bat = reg_wr && (reg_addr == `PMSR_ADDR_BAT_MON);
  wire wr_therm = reg_wr && (reg_addr == `PMSR_ADDR_THERM);
  wire wr_b1 = reg_wr && (reg_addr == `PMSR_ADDR_B1_CTRL);
  wire wr_b2_pri = reg_wr && (reg_addr == `PMSR_ADDR_B2_PRI);
  wire wr_b2_sec = reg_wr && (reg_addr == `PMSR_ADDR_B2_SEC);
  wire wr_b2 = reg_wr && (reg_addr == `PMSR_ADDR_B2_CTRL);
  wire wr_b3_pri = reg_wr && (reg_addr == `PMSR_ADDR_B3_PRI);
  wire [1:0] wr_ctrl = {wr_b2, wr_b1};

  always @(posedge clock) begin
    if (!nrst) begin
      battery_irq_unmask <= 1'b0;
      battery_spare <= 1'b0;
      battery_threshold_code <= 4'h0;
      thermal_irq_unmask <= 1'b0;
      thermal_spare <= 6'h00;
      primary_voltage_code <= `PMSR_RST_VCODE;
      secondary_voltage_code <= `PMSR_RST_VCODE;
      b3_primary_voltage_code <= `PMSR_RST_VCODE;
    end else if (clk_en) begin
      if (wr_bat) begin
        battery_irq_unmask <= reg_wdata[`PMSR_BIT_UNMASK];
        battery_spare <= reg_wdata[`PMSR_BIT_BAT_SPARE];
        battery_threshold_code <= reg_wdata[3:0];
      end
      if (wr_therm) begin
        thermal_irq_unmask <= reg_wdata[`PMSR_BIT_UNMASK];
        thermal_spare <= reg_wdata[5:0];
      end
      if (wr_b2_pri) begin
        primary_voltage_code <= reg_wdata[5:0];
      end
      if (wr_b2_sec) begin
        secondary_voltage_code <= reg_wdata[5:0];
      end
      if (wr_b3_pri) begin
        b3_primary_voltage_code <= reg_wdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // per-regulator control bits
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ctrl
      always @(posedge clock) begin
        if (!nrst) begin
          buck_enable[gi] <= 1'b0;
          buck_phase[gi] <= 1'b0;
          fault_irq_unmask[gi] <= 1'b0;
        end else if (clk_en && wr_ctrl[gi]) begin
          buck_enable[gi] <= reg_wdata[`PMSR_BIT_ENABLE];
          buck_phase[gi] <= reg_wdata[`PMSR_BIT_PHASE];
          fault_irq_unmask[gi] <= reg_wdata[`PMSR_BIT_FAULT_UNMASK];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt status: flags follow the unmasked live condition
  // ----------------------------------------------------------------
  wire [1:0] fault_hit = fault_live & fault_irq_unmask;

  always @(posedge clock) begin
    if (!nrst) begin
      battery_irq_flag <= 1'b0;
      thermal_irq_flag <= 1'b0;
      irq_request <= 1'b0;
    end else if (clk_en) begin
      battery_irq_flag <= battery_low_live && battery_irq_unmask;
      thermal_irq_flag <= thermal_live && thermal_irq_unmask;
      irq_request <= (battery_low_live && battery_irq_unmask) ||
                     (thermal_live && thermal_irq_unmask) ||
                     (|fault_hit);
    end
  end

  // ----------------------------------------------------------------
  // voltage code selection
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!nrst) begin
      buck_two_vcode <= `PMSR_RST_VCODE;
      buck_three_vcode <= `PMSR_RST_VCODE;
    end else if (clk_en) begin
      buck_two_vcode <= voltage_select_pin_live ? secondary_voltage_code : primary_voltage_code;
      buck_three_vcode <= b3_primary_voltage_code;
    end
  end

  // ----------------------------------------------------------------
  // read path, unmapped addresses read zero
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `PMSR_ADDR_BAT_MON: begin
        next_rdata = {battery_irq_unmask, battery_irq_flag, battery_low_live,
                      battery_spare, battery_threshold_code};
      end
      `PMSR_ADDR_THERM: begin
        next_rdata = {thermal_irq_unmask, thermal_irq_flag, thermal_spare};
      end
      `PMSR_ADDR_B1_CTRL: begin
        next_rdata = {buck_enable[0], 4'h0, buck_phase[0], fault_irq_unmask[0],
                      pgood_live[0]};
      end
      `PMSR_ADDR_B2_PRI: begin
        next_rdata = {2'b00, primary_voltage_code};
      end
      `PMSR_ADDR_B2_SEC: begin
        next_rdata = {2'b00, secondary_voltage_code};
      end
      `PMSR_ADDR_B2_CTRL: begin
        next_rdata = {buck_enable[1], 4'h0, buck_phase[1], fault_irq_unmask[1],
                      pgood_live[1]};
      end
      `PMSR_ADDR_B3_PRI: begin
        next_rdata = {2'b00, b3_primary_voltage_code};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ===== verification/pmsr_host.sv
// host model: register cycles and the select pin
`timescale 1ns/1ps
module pmsr_host (
  // clock
  input logic clock,
  // register port
  input logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  // select pin
  output logic voltage_select_pin
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, voltage_select_pin} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic sel(input logic v);
    @(negedge clock);
    voltage_select_pin = v;
  endtask
endmodule

// ===== verification/pmsr_regs_assertions.sv
// assertions on the register bank ports
`timescale 1ns/1ps
module pmsr_regs_chk (
  // clock and reset
  input logic clock,
  input logic nrst,
  input logic clk_en,
  // register port
  input logic [7:0] reg_addr,
  input logic reg_wr,
  input logic [7:0] reg_wdata,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  // status pins
  input logic battery_low_cmp,
  input logic thermal_event,
  input logic [1:0] buck_pgood,
  input logic [1:0] buck_fault,
  input logic voltage_select_pin,
  // regulator controls
  input logic [3:0] battery_threshold_code,
  input logic [1:0] buck_enable,
  input logic [1:0] buck_phase,
  input logic [5:0] buck_two_vcode,
  input logic [5:0] buck_three_vcode,
  input logic irq_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire wok = reg_wr && clk_en;
  wire rok = reg_rd && clk_en;
  a_thr_code: assert property (
    wok && reg_addr == 8'h00 |=> battery_threshold_code == $past(reg_wdata[3:0]))
    else $error("threshold code lost");
  a_buck_on: assert property (
    wok && reg_addr == 8'h12 |=> buck_enable[0] == $past(reg_wdata[7]))
    else $error("enable lost");
  a_phase_two: assert property (
    wok && reg_addr == 8'h22 |=> buck_phase[1] == $past(reg_wdata[2]))
    else $error("phase lost");
  a_b3_code: assert property (
    wok && reg_addr == 8'h30 |-> ##2 buck_three_vcode == $past(reg_wdata[5:0], 2))
    else $error("code lost");
  a_irq_cause: assert property (
    irq_request |-> $past(battery_low_cmp, 3) || $past(thermal_event, 3)
      || $past(buck_fault, 3) != 2'b00)
    else $error("irq without cause");
  a_rdata_hold: assert property (!rok |=> $stable(reg_rdata))
    else $error("read data moved");
  a_unmapped_rd: assert property (
    rok && reg_addr > 8'h30 && reg_addr[1:0] == 2'b01 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_volt_rsvd: assert property (
    rok && reg_addr[5] && !reg_addr[1] |=> reg_rdata[7:6] == 2'b00)
    else $error("voltage reserved set");
  a_ctrl_rsvd: assert property (
    rok && reg_addr[4] && reg_addr[1] |=> reg_rdata[6:3] == 4'h0)
    else $error("control reserved set");
endmodule
bind pmsr_regs pmsr_regs_chk u_chk (
  .clock(clock),
  .nrst(nrst),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .battery_low_cmp(battery_low_cmp),
  .thermal_event(thermal_event),
  .buck_pgood(buck_pgood),
  .buck_fault(buck_fault),
  .voltage_select_pin(voltage_select_pin),
  .battery_threshold_code(battery_threshold_code),
  .buck_enable(buck_enable),
  .buck_phase(buck_phase),
  .buck_two_vcode(buck_two_vcode),
  .buck_three_vcode(buck_three_vcode),
  .irq_request(irq_request)
);

// ===== verification/pmsr_system_regulator_regs_tb_top.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
module pmsr_system_regulator_regs_tb_top;
  logic clock = 1'b0, nrst = 1'b0, clk_en = 1'b1, battery_low_cmp = 1'b0, thermal_event = 1'b0;
  logic [1:0] buck_pgood = 2'b00, buck_fault = 2'b00, buck_enable, buck_phase;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, voltage_select_pin, irq_request;
  logic [3:0] battery_threshold_code;
  logic [5:0] buck_two_vcode, buck_three_vcode;
  int err_total = 0, samples_checked = 0;
  always #2.5 clock = ~clock;
  pmsr_host host (
    .clock(clock),
    .reg_rdata(reg_rdata),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .voltage_select_pin(voltage_select_pin)
  );
  pmsr_regs dut (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .battery_low_cmp(battery_low_cmp),
    .thermal_event(thermal_event),
    .buck_pgood(buck_pgood),
    .buck_fault(buck_fault),
    .voltage_select_pin(voltage_select_pin),
    .battery_threshold_code(battery_threshold_code),
    .buck_enable(buck_enable),
    .buck_phase(buck_phase),
    .buck_two_vcode(buck_two_vcode),
    .buck_three_vcode(buck_three_vcode),
    .irq_request(irq_request)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic w4;
    repeat (4) @(negedge clock);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    rdc(8'h12, 8'h00);
    host.wr(8'h00, 8'h95);
    battery_low_cmp = 1'b1;
    w4;
    rdc(8'h00, 8'hf5);
    chk({7'h00, irq_request}, 8'h01);
    chk({4'h0, battery_threshold_code}, 8'h05);
    host.wr(8'h00, 8'h15);
    w4;
    rdc(8'h00, 8'h35);
    chk({7'h00, irq_request}, 8'h00);
    battery_low_cmp = 1'b0;
    w4;
    rdc(8'h00, 8'h15);
    $display("test battery done");
    host.wr(8'h01, 8'hbf);
    thermal_event = 1'b1;
    w4;
    rdc(8'h01, 8'hff);
    host.wr(8'h01, 8'h3f);
    w4;
    rdc(8'h01, 8'h3f);
    chk({7'h00, irq_request}, 8'h00);
    thermal_event = 1'b0;
    $display("test thermal done");
    buck_pgood = 2'b11;
    host.wr(8'h22, 8'hff);
    host.wr(8'h12, 8'h06);
    w4;
    rdc(8'h22, 8'h87);
    rdc(8'h12, 8'h07);
    chk({4'h0, buck_enable, buck_phase}, 8'h0b);
    buck_fault = 2'b01;
    w4;
    chk({7'h00, irq_request}, 8'h01);
    host.wr(8'h12, 8'h04);
    w4;
    chk({7'h00, irq_request}, 8'h00);
    buck_pgood = 2'b00;
    w4;
    rdc(8'h12, 8'h04);
    $display("test buck done");
    host.wr(8'h20, 8'hff);
    host.wr(8'h21, 8'h2a);
    host.wr(8'h30, 8'h15);
    w4;
    rdc(8'h20, 8'h3f);
    rdc(8'h21, 8'h2a);
    rdc(8'h30, 8'h15);
    chk({2'b00, buck_two_vcode}, 8'h3f);
    host.sel(1'b1);
    w4;
    chk({2'b00, buck_two_vcode}, 8'h2a);
    chk({2'b00, buck_three_vcode}, 8'h15);
    rdc(8'h45, 8'h00);
    $display("test voltage done");
    nrst = 1'b0;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    rdc(8'h22, 8'h00);
    chk({2'b00, buck_two_vcode}, 8'h00);
    clk_en = 1'b0;
    host.wr(8'h12, 8'h86);
    clk_en = 1'b1;
    rdc(8'h12, 8'h00);
    chk({6'h00, buck_enable}, 8'h00);
    host.wr(8'h12, 8'h86);
    rdc(8'h12, 8'h86);
    chk({6'h00, buck_enable}, 8'h01);
    $display("test reset and enable done");
    wrap_up;
  end
endmodule
